// >>> verilog/opsf_top.sv
// Purpose: drains the output buffer at a fill-dependent pace inside a synthetic frame
// Assumes: clk_sys is the master clock; cfg port writes are single-cycle strobes
// Notes:   pixel_out_clock is a one-cycle strobe per output pixel; pad logic forms the pin
// Function
// - third pace clock divides master clock by 4-bit divisor in bits 3:0.
// - switch second to third pace clock at three quarters buffer fill.
// - third divisor zero acts like one, master clock passes undivided.
// - edge-rate bits 7:5 drive clock pin when third pace clock selected.
// - line-active strobe stays high for width field output clocks.
// - height field sets line-active pulses per frame-active assertion.
// - height ignored while output configuration bit 5 is set.
// - wait lead field clocks before raising line-active; software keeps lead >= 5.
// - insert trail field clocks after line-active falls; software keeps trail >= 5.
// - first and second pace clocks use own 4-bit divisors, zero as one.
// - switch first to second pace clock at half buffer fill.
// - shadow copy at end of input vertical blanking unless hold bit set.
`timescale 1ns/1ps
`default_nettype none
module opsf_top (
    input  wire logic                        clk_sys,
    input  wire logic                        srst,
    input  wire logic                        cfg_wr,
    input  wire logic [7:0]                  cfg_addr,
    input  wire logic [15:0]                 cfg_wdata,
    output logic [15:0]                      cfg_rdata,
    input  wire logic [3:0]                  first_clock_divisor,
    input  wire logic [2:0]                  first_clock_slew,
    input  wire logic [3:0]                  second_clock_divisor,
    input  wire logic [2:0]                  second_clock_slew,
    input  wire logic                        height_ignore,
    input  wire logic                        shadow_hold,
    input  wire logic                        vblank_end,
    input  wire logic                        in_valid,
    output logic                             in_ready,
    input  wire logic [opsf_pkg::DATA_W-1:0] in_data,
    output logic                             pixel_out_clock,
    output logic [2:0]                       clock_slew,
    output opsf_pkg::opsf_pix_s              pix_out
);
    opsf_pkg::opsf_cfg_s   reg_r, reg_nxt, sh_r, sh_nxt;
    logic [3:0]            sh1_div_r, sh2_div_r, sh1_div_nxt, sh2_div_nxt;
    logic [15:0]           rdata_nxt;
    opsf_pkg::opsf_sel_e   sel_r, sel_nxt;
    logic [3:0]            div_cnt_r, div_cnt_nxt, cur_div, eff_div;
    logic [2:0]            slew_nxt;
    logic                  tick;
    opsf_pkg::opsf_state_e st_r, st_nxt;
    logic [11:0]           pix_cnt_r, pix_cnt_nxt, line_cnt_r, line_cnt_nxt;
    logic [7:0]            gap_cnt_r, gap_cnt_nxt;
    opsf_pkg::opsf_pix_s   pix_nxt;
    logic                  fifo_valid, fifo_pop;
    logic [opsf_pkg::DATA_W-1:0] fifo_data;
    logic [2:0]            fill;
    logic [7:0]            lead_v, trail_v;
    logic                  last_line;

    // buffer between image pipeline and output pins
    opsf_fifo #(
        .W (opsf_pkg::DATA_W),
        .D (opsf_pkg::FIFO_DEPTH),
        .C (opsf_pkg::CNT_W)
    ) u_fifo (
        .clk_sys   (clk_sys),
        .srst      (srst),
        .in_valid  (in_valid),
        .in_ready  (in_ready),
        .in_data   (in_data),
        .out_valid (fifo_valid),
        .out_ready (fifo_pop),
        .out_data  (fifo_data),
        .fill      (fill)
    );

    // register file writes, readback and shadow transfer
    always_comb begin
        reg_nxt     = reg_r;
        sh_nxt      = sh_r;
        sh1_div_nxt = sh1_div_r;
        sh2_div_nxt = sh2_div_r;
        rdata_nxt   = 16'h0000;
        if (cfg_wr) begin
            case (cfg_addr)
                opsf_pkg::ADDR_CLK3:   reg_nxt.clk3   = cfg_wdata[7:0];
                opsf_pkg::ADDR_WIDTH:  reg_nxt.width  = cfg_wdata[11:0];
                opsf_pkg::ADDR_HEIGHT: reg_nxt.height = cfg_wdata[11:0];
                opsf_pkg::ADDR_TIMING: reg_nxt.timing = cfg_wdata;
                default:               reg_nxt        = reg_r;
            endcase
        end
        case (cfg_addr)
            opsf_pkg::ADDR_CLK3:   rdata_nxt = {8'h00, reg_r.clk3 & 8'hef};
            opsf_pkg::ADDR_WIDTH:  rdata_nxt = {4'h0, reg_r.width};
            opsf_pkg::ADDR_HEIGHT: rdata_nxt = {4'h0, reg_r.height};
            opsf_pkg::ADDR_TIMING: rdata_nxt = reg_r.timing;
            default:               rdata_nxt = 16'h0000;
        endcase
        // shadow update gate
        // copying only at vblank end keeps the running frame consistent
        if (vblank_end && !shadow_hold) begin
            sh_nxt      = reg_r;
            sh1_div_nxt = first_clock_divisor;
            sh2_div_nxt = second_clock_divisor;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            reg_r     <= '{opsf_pkg::RST_CLK3, opsf_pkg::RST_WIDTH,
                           opsf_pkg::RST_HEIGHT, opsf_pkg::RST_TIMING};
            sh_r      <= '{opsf_pkg::RST_CLK3, opsf_pkg::RST_WIDTH,
                           opsf_pkg::RST_HEIGHT, opsf_pkg::RST_TIMING};
            sh1_div_r <= 4'h1;
            sh2_div_r <= 4'h1;
            cfg_rdata <= 16'h0000;
        end else begin
            reg_r     <= reg_nxt;
            sh_r      <= sh_nxt;
            sh1_div_r <= sh1_div_nxt;
            sh2_div_r <= sh2_div_nxt;
            cfg_rdata <= rdata_nxt;
        end
    end

    // pace source selection, divider and slew choice
    always_comb begin
        if (fill >= opsf_pkg::FILL_3Q) begin
            sel_nxt = opsf_pkg::SEL_THREE;
        end else if (fill >= opsf_pkg::FILL_HALF) begin
            sel_nxt = opsf_pkg::SEL_TWO;
        end else begin
            sel_nxt = opsf_pkg::SEL_ONE;
        end
        case (sel_r)
            opsf_pkg::SEL_THREE: cur_div = sh_r.clk3[opsf_pkg::DIV_MSB:opsf_pkg::DIV_LSB];
            opsf_pkg::SEL_TWO:   cur_div = sh2_div_r;
            default:             cur_div = sh1_div_r;
        endcase
        eff_div     = (cur_div == 4'h0) ? 4'h1 : cur_div;
        tick        = (div_cnt_r >= eff_div - 4'h1);
        div_cnt_nxt = tick ? 4'h0 : div_cnt_r + 4'h1;
        case (sel_r)
            opsf_pkg::SEL_THREE: slew_nxt = sh_r.clk3[opsf_pkg::SLEW_MSB:opsf_pkg::SLEW_LSB];
            opsf_pkg::SEL_TWO:   slew_nxt = second_clock_slew;
            default:             slew_nxt = first_clock_slew;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            sel_r           <= opsf_pkg::SEL_ONE;
            div_cnt_r       <= 4'h0;
            clock_slew      <= 3'h0;
            pixel_out_clock <= 1'b0;
        end else begin
            sel_r           <= sel_nxt;
            div_cnt_r       <= div_cnt_nxt;
            clock_slew      <= slew_nxt;
            pixel_out_clock <= tick;
        end
    end

    // synthetic frame sequencer, advanced once per output pixel clock
    assign lead_v    = sh_r.timing[opsf_pkg::LEAD_MSB:opsf_pkg::LEAD_LSB];
    assign trail_v   = sh_r.timing[opsf_pkg::TRAIL_MSB:opsf_pkg::TRAIL_LSB];
    // height ignored
    // with height ignored the frame runs until the buffer drains
    assign last_line = height_ignore ? !fifo_valid : (line_cnt_r + 12'h001 >= sh_r.height);
    assign fifo_pop  = tick && (st_nxt == opsf_pkg::ST_LINE); // pops line up with line-active

    always_comb begin
        st_nxt       = st_r;
        pix_cnt_nxt  = pix_cnt_r;
        line_cnt_nxt = line_cnt_r;
        gap_cnt_nxt  = gap_cnt_r;
        pix_nxt      = pix_out;
        if (tick) begin
            case (st_r)
                opsf_pkg::ST_IDLE: begin
                    if (fifo_valid) begin
                        st_nxt       = opsf_pkg::ST_LEAD;
                        gap_cnt_nxt  = 8'h01;
                        line_cnt_nxt = 12'h000;
                    end
                end
                opsf_pkg::ST_LEAD: begin
                    if (gap_cnt_r >= lead_v) begin
                        st_nxt      = opsf_pkg::ST_LINE;
                        pix_cnt_nxt = 12'h001;
                    end else begin
                        gap_cnt_nxt = gap_cnt_r + 8'h01;
                    end
                end
                opsf_pkg::ST_LINE: begin
                    if (pix_cnt_r >= sh_r.width) begin
                        st_nxt      = opsf_pkg::ST_TRAIL;
                        gap_cnt_nxt = 8'h01;
                    end else begin
                        pix_cnt_nxt = pix_cnt_r + 12'h001;
                    end
                end
                opsf_pkg::ST_TRAIL: begin
                    if (gap_cnt_r < trail_v) begin
                        gap_cnt_nxt = gap_cnt_r + 8'h01;
                    end else if (last_line) begin
                        st_nxt = opsf_pkg::ST_IDLE;
                    end else begin
                        st_nxt       = opsf_pkg::ST_LEAD;
                        gap_cnt_nxt  = 8'h01;
                        line_cnt_nxt = line_cnt_r + 12'h001;
                    end
                end
                default: st_nxt = opsf_pkg::ST_IDLE;
            endcase
            pix_nxt.frame_valid = (st_nxt != opsf_pkg::ST_IDLE);
            pix_nxt.line_valid  = (st_nxt == opsf_pkg::ST_LINE);
            // underrun sends zero rather than stalling the line
            pix_nxt.data = (st_nxt == opsf_pkg::ST_LINE && fifo_valid) ? fifo_data : '0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            st_r       <= opsf_pkg::ST_IDLE;
            pix_cnt_r  <= 12'h000;
            line_cnt_r <= 12'h000;
            gap_cnt_r  <= 8'h00;
            pix_out    <= '0;
        end else begin
            st_r       <= st_nxt;
            pix_cnt_r  <= pix_cnt_nxt;
            line_cnt_r <= line_cnt_nxt;
            gap_cnt_r  <= gap_cnt_nxt;
            pix_out    <= pix_nxt;
        end
    end

    // checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (srst);

    chk_three_step: assert property (fill >= 3'h3 |=> sel_r == opsf_pkg::SEL_THREE)
        else $error("third pace clock not selected at 3/4 fill");
    chk_half_step: assert property (fill == 3'h2 |=> sel_r == opsf_pkg::SEL_TWO)
        else $error("second pace clock not selected at half fill");
    chk_zero_div: assert property (cur_div <= 4'h1 |=> pixel_out_clock)
        else $error("divisor zero or one did not pass master clock");
    chk_slew_three: assert property (sel_r == opsf_pkg::SEL_THREE
        |=> clock_slew == $past(sh_r.clk3[7:5]))
        else $error("clock slew not from third config");
    chk_line_width: assert property (tick && st_r == opsf_pkg::ST_LINE
        && st_nxt == opsf_pkg::ST_TRAIL |-> pix_cnt_r == sh_r.width)
        else $error("line length differs from width");
    chk_frame_lines: assert property (st_r == opsf_pkg::ST_TRAIL
        && st_nxt == opsf_pkg::ST_IDLE && !height_ignore
        |-> line_cnt_r + 12'h001 >= sh_r.height)
        else $error("frame ended before height reached");
    chk_lead_len: assert property (st_r == opsf_pkg::ST_LEAD
        && st_nxt == opsf_pkg::ST_LINE |-> gap_cnt_r >= lead_v)
        else $error("line raised before lead elapsed");
    chk_shadow_load: assert property (vblank_end && !shadow_hold
        |=> sh_r == $past(reg_r))
        else $error("shadow not loaded at vblank end");
    chk_gap_low: assert property ($rose(pix_out.line_valid)
        |-> $past(st_r) == opsf_pkg::ST_LEAD && pix_out.frame_valid)
        else $error("line valid rose outside lead end");
    cov_frame_end: cover property ($fell(pix_out.frame_valid));
    cov_third_sel: cover property (sel_r == opsf_pkg::SEL_THREE ##1 sel_r == opsf_pkg::SEL_TWO);
    cov_full_stall: cover property (!in_ready && in_valid);
endmodule
`default_nettype wire

// >>> verilog/opsf_pkg.sv
// Purpose: shared constants and types for the output pacing and synthetic frame stage
// Assumes: registers sit at their printed offsets on a plain write/read port
// Notes:   field positions and reset values are named once here
package opsf_pkg;
    // register offsets
    localparam logic [7:0]  ADDR_CLK3      = 8'h0f;
    localparam logic [7:0]  ADDR_WIDTH     = 8'h10;
    localparam logic [7:0]  ADDR_HEIGHT    = 8'h11;
    localparam logic [7:0]  ADDR_TIMING    = 8'h12;
    // reset values
    localparam logic [7:0]  RST_CLK3       = 8'h03;
    localparam logic [11:0] RST_WIDTH      = 12'h640;
    localparam logic [11:0] RST_HEIGHT     = 12'h258;
    localparam logic [15:0] RST_TIMING     = 16'h0606;
    // field positions
    localparam int          DIV_LSB        = 0;
    localparam int          DIV_MSB        = 3;
    localparam int          SLEW_LSB       = 5;
    localparam int          SLEW_MSB       = 7;
    localparam int          LEAD_LSB       = 0;
    localparam int          LEAD_MSB       = 7;
    localparam int          TRAIL_LSB      = 8;
    localparam int          TRAIL_MSB      = 15;
    // buffer shape and fill thresholds
    localparam int          DATA_W         = 8;
    localparam int          FIFO_DEPTH     = 4;
    localparam int          CNT_W          = 3;
    localparam logic [2:0]  FILL_HALF      = 3'(FIFO_DEPTH / 2);
    localparam logic [2:0]  FILL_3Q        = 3'((FIFO_DEPTH * 3) / 4);

    typedef struct packed {
        logic [7:0]  clk3;
        logic [11:0] width;
        logic [11:0] height;
        logic [15:0] timing;
    } opsf_cfg_s;

    typedef struct packed {
        logic              frame_valid;
        logic              line_valid;
        logic [DATA_W-1:0] data;
    } opsf_pix_s;

    typedef enum logic [3:0] {
        ST_IDLE  = 4'b0001,
        ST_LEAD  = 4'b0010,
        ST_LINE  = 4'b0100,
        ST_TRAIL = 4'b1000
    } opsf_state_e;

    typedef enum logic [2:0] {
        SEL_ONE   = 3'b001,
        SEL_TWO   = 3'b010,
        SEL_THREE = 3'b100
    } opsf_sel_e;
endpackage

// >>> verilog/opsf_fifo.sv
// Purpose: small output buffer with valid/ready on both sides and a fill count
// Assumes: one clock, synchronous active-high reset
// Notes:   fill count feeds the pacing clock selection
`timescale 1ns/1ps
`default_nettype none
module opsf_fifo #(
    parameter int W = 8,
    parameter int D = 4,
    parameter int C = 3
) (
    input  wire logic         clk_sys,
    input  wire logic         srst,
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data,
    output logic [C-1:0]      fill
);
    logic [W-1:0]         mem_r [D];
    logic [$clog2(D)-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
    logic [C-1:0]         cnt_r, cnt_nxt;
    logic                 push, pop;
    logic                 rdy_r, rdy_nxt;

    // ready is registered so the top output comes from a flop
    assign in_ready  = rdy_r;
    assign out_valid = (cnt_r != '0);
    assign out_data  = mem_r[rp_r];
    assign fill      = cnt_r;
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    // pointer and count next values
    always_comb begin
        wp_nxt  = push ? wp_r + 1'b1 : wp_r;
        rp_nxt  = pop ? rp_r + 1'b1 : rp_r;
        cnt_nxt = cnt_r + C'(push) - C'(pop);
        rdy_nxt = (cnt_nxt != C'(D));
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            wp_r  <= '0;
            rp_r  <= '0;
            cnt_r <= '0;
            rdy_r <= 1'b1;
        end else begin
            wp_r  <= wp_nxt;
            rp_r  <= rp_nxt;
            cnt_r <= cnt_nxt;
            rdy_r <= rdy_nxt;
        end
    end

    // storage needs no reset; only written entries are read
    always_ff @(posedge clk_sys) begin
        if (push) begin
            mem_r[wp_r] <= in_data;
        end
    end
endmodule
`default_nettype wire

// >>> verif/opsf_host_rx.sv
// Purpose: host capture port model, measures synthetic frame timing in pixel ticks
// Assumes: pix_out is valid on every cycle that pixel_out_clock is high
// Notes:   passive receiver; this port has no back-pressure, so it never stalls
`timescale 1ns/1ps
`default_nettype none
module opsf_host_rx (
    input  wire logic                clk_sys,
    input  wire logic                srst,
    input  wire logic                pixel_out_clock,
    input  wire opsf_pkg::opsf_pix_s pix_out,
    output int                       lead_seen,
    output int                       trail_seen,
    output int                       gap_seen,
    output int                       width_lo,
    output int                       width_hi,
    output int                       lines_seen,
    output int                       frames_seen
);
    logic       fv_r;
    logic       lv_r;
    int         run;
    logic [7:0] rx_q[$];

    // run counts ticks of the present phase and restarts at every strobe edge except the fall of frame_valid
    always @(posedge clk_sys) begin
        if (srst) begin
            fv_r        <= 1'b0;
            lv_r        <= 1'b0;
            frames_seen <= 0;
        end else if (pixel_out_clock) begin
            fv_r <= pix_out.frame_valid;
            lv_r <= pix_out.line_valid;
            run  <= run + 1;
            if (pix_out.frame_valid && pix_out.line_valid)
                rx_q.push_back(pix_out.data);
            if (pix_out.frame_valid && !fv_r) begin
                run        <= 1;
                lines_seen <= 0;
                width_lo   <= 4096;
                width_hi   <= 0;
            end else if (!pix_out.frame_valid && fv_r) begin
                trail_seen  <= run;
                frames_seen <= frames_seen + 1;
            end else if (pix_out.line_valid && !lv_r) begin
                // first rise ends the lead, later rises end trail plus lead
                if (lines_seen == 0)
                    lead_seen <= run;
                else
                    gap_seen <= run;
                lines_seen <= lines_seen + 1;
                run        <= 1;
            end else if (!pix_out.line_valid && lv_r) begin
                if (run < width_lo)
                    width_lo <= run;
                if (run > width_hi)
                    width_hi <= run;
                run <= 1;
            end
        end
    end
endmodule
`default_nettype wire

// >>> verif/output_pacing_spoof_frame_bench.sv
// Purpose: self-checking bench for the output pacing and synthetic frame stage
// Assumes: inputs change 1 ns after the rising edge of clk_sys
// Notes:   random frames stay small so the run ends far below the watchdog
`timescale 1ns/1ps
`default_nettype none
module output_pacing_spoof_frame_bench;
    logic                clk_sys = 1'b0;
    logic                srst = 1'b1;
    logic                cfg_wr = 1'b0;
    logic [7:0]          cfg_addr = 8'h00;
    logic [15:0]         cfg_wdata = 16'h0000;
    logic [15:0]         cfg_rdata;
    logic [3:0]          first_clock_divisor = 4'h1;
    logic [2:0]          first_clock_slew = 3'h0;
    logic [3:0]          second_clock_divisor = 4'h1;
    logic [2:0]          second_clock_slew = 3'h0;
    logic                height_ignore = 1'b0;
    logic                shadow_hold = 1'b0;
    logic                vblank_end = 1'b0;
    logic                in_valid = 1'b0;
    logic                in_ready;
    logic [7:0]          in_data = 8'h00;
    logic                pixel_out_clock;
    logic [2:0]          clock_slew;
    opsf_pkg::opsf_pix_s pix_out;
    int                  lead_seen, trail_seen, gap_seen, width_lo, width_hi;
    int                  lines_seen, frames_seen;
    int                  num_errors = 0;
    int                  compares = 0;
    logic [31:0]         seed = 32'h063fbf53;
    logic [7:0]          sent_q[$];

    opsf_top opsf_top_inst (.clk_sys(clk_sys), .srst(srst), .cfg_wr(cfg_wr),
        .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
        .first_clock_divisor(first_clock_divisor), .first_clock_slew(first_clock_slew),
        .second_clock_divisor(second_clock_divisor), .second_clock_slew(second_clock_slew),
        .height_ignore(height_ignore), .shadow_hold(shadow_hold), .vblank_end(vblank_end),
        .in_valid(in_valid), .in_ready(in_ready), .in_data(in_data),
        .pixel_out_clock(pixel_out_clock), .clock_slew(clock_slew), .pix_out(pix_out));
    opsf_host_rx opsf_host_rx_inst (.clk_sys(clk_sys), .srst(srst),
        .pixel_out_clock(pixel_out_clock), .pix_out(pix_out), .lead_seen(lead_seen),
        .trail_seen(trail_seen), .gap_seen(gap_seen), .width_lo(width_lo),
        .width_hi(width_hi), .lines_seen(lines_seen), .frames_seen(frames_seen));

    // 125 MHz master clock
    always #4 clk_sys = ~clk_sys;

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    // height ignored: frame ends once the buffer runs dry at a line end
    function automatic int exp_lines(input int w, input int h, input int n, input logic ign);
        if (ign)
            return n / w;
        return (h == 0) ? 1 : h;
    endfunction
    task automatic step();
        @(posedge clk_sys);
        #1;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected %s: expected %0h seen %0h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        cfg_wr    = 1'b1;
        cfg_addr  = a;
        cfg_wdata = d;
        step();
        cfg_wr = 1'b0;
        step();
    endtask
    task automatic rd(input logic [7:0] a, input logic [15:0] e);
        cfg_addr = a;
        step();
        step();
        chk("cfg_rdata", {16'h0000, e}, {16'h0000, cfg_rdata});
    endtask
    task automatic vb();
        vblank_end = 1'b1;
        step();
        vblank_end = 1'b0;
        step();
    endtask
    // word is taken at the edge where in_ready was high beforehand
    task automatic push(input int n);
        logic took;
        for (int i = 0; i < n; i++) begin
            in_data  = 8'(rnd());
            in_valid = 1'b1;
            sent_q.push_back(in_data);
            do begin
                took = in_ready;
                step();
            end while (took !== 1'b1);
        end
        in_valid = 1'b0;
    endtask
    // second interval is measured so a divider change has settled
    task automatic pace(input int ep, input logic [2:0] es);
        int p;
        for (int r = 0; r < 2; r++) begin
            p = 0;
            while (pixel_out_clock !== 1'b1 && p < 64) begin
                step();
                p++;
            end
            p = 0;
            do begin
                step();
                p++;
            end while (pixel_out_clock !== 1'b1 && p < 64);
        end
        chk("pace period", ep, p);
        chk("clock_slew", {29'h0, es}, {29'h0, clock_slew});
    endtask
    task automatic frame(input int w, input int h, input int ld, input int tr, input int n,
                         input logic ign, input int ep, input logic [2:0] es);
        int f;
        int k;
        wr(opsf_pkg::ADDR_WIDTH, 16'(w));
        wr(opsf_pkg::ADDR_HEIGHT, 16'(h));
        wr(opsf_pkg::ADDR_TIMING, {8'(tr), 8'(ld)});
        height_ignore = ign;
        vb();
        f = frames_seen;
        push(n);
        if (ep != 0)
            pace(ep, es);
        k = 0;
        while (frames_seen == f && k < 30000) begin
            step();
            k++;
        end
        chk("frames", f + 1, frames_seen);
        chk("lead", ld, lead_seen);
        chk("width min", w, width_lo);
        chk("width max", w, width_hi);
        chk("trail", tr, trail_seen);
        chk("lines", exp_lines(w, h, n, ign), lines_seen);
        if (lines_seen > 1)
            chk("line gap", ld + tr, gap_seen);
    endtask
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // main sequence
    initial begin
        int w;
        int h;
        repeat (8) @(posedge clk_sys);
        #1 srst = 1'b0;
        rd(8'h0f, 16'h0003);
        rd(8'h10, 16'h0640);
        rd(8'h11, 16'h0258);
        rd(8'h12, 16'h0606);
        wr(8'h0e, 16'h1234);
        rd(8'h0e, 16'h0000);
        wr(8'h0f, 16'hffff);
        rd(8'h0f, 16'h00ef);
        wr(8'h12, 16'hffff);
        rd(8'h12, 16'hffff);
        $display("test registers done");
        first_clock_divisor = 4'h0;
        first_clock_slew    = 3'h5;
        vb();
        pace(1, 3'h5);
        first_clock_divisor = 4'h2;
        vb();
        pace(2, 3'h5);
        shadow_hold         = 1'b1;
        first_clock_divisor = 4'h6;
        vb();
        pace(2, 3'h5);
        shadow_hold = 1'b0;
        vb();
        pace(6, 3'h5);
        $display("test first source and shadow done");
        first_clock_divisor  = 4'h1;
        second_clock_divisor = 4'h3;
        second_clock_slew    = 3'h2;
        frame(2, 1, 200, 5, 2, 1'b0, 3, 3'h2);
        wr(opsf_pkg::ADDR_CLK3, 16'h00a4);
        frame(4, 1, 200, 5, 4, 1'b0, 4, 3'h5);
        wr(opsf_pkg::ADDR_CLK3, 16'h0060);
        frame(4, 1, 200, 6, 4, 1'b0, 1, 3'h3);
        frame(2, 3, 5, 5, 6, 1'b0, 0, 3'h0);
        frame(6, 1, 8, 7, 12, 1'b1, 0, 3'h0);
        $display("test pacing and corner frames done");
        for (int i = 0; i < 10; i++) begin
            first_clock_divisor  = 4'(rnd() % 3);
            first_clock_slew     = 3'(rnd());
            second_clock_divisor = 4'(rnd() % 4);
            second_clock_slew    = 3'(rnd());
            wr(opsf_pkg::ADDR_CLK3, 16'(rnd() & 32'he3));
            // software keeps widths even and lead, trail at least five
            w = 2 * (1 + int'(rnd() % 6));
            h = int'(rnd() % 4);
            frame(w, h, 5 + int'(rnd() % 16), 5 + int'(rnd() % 16), w * ((h == 0) ? 1 : h),
                  1'b0, 0, 3'h0);
        end
        $display("test random frames done");
        chk("words received", sent_q.size(), opsf_host_rx_inst.rx_q.size());
        for (int i = 0; i < sent_q.size() && i < opsf_host_rx_inst.rx_q.size(); i++)
            chk("pixel data", sent_q[i], opsf_host_rx_inst.rx_q[i]);
        $display("test data order done");
        final_report();
    end

    // watchdog cuts a hang short
    initial begin
        repeat (90000) @(posedge clk_sys);
        num_errors++;
        $display("unexpected run length: expected end seen timeout");
        final_report();
    end
endmodule
`default_nettype wire
